// >>> design/i2c_scl_timing_and_status.sv
// Purpose: scl count registers, master scl timing, start and general call status
// Assumes: sda and scl pins are asynchronous and open drain
// Notes: read data appear one cycle after rd_en; unmapped reads give zero
// Summary of operation
// - standard low count below 8 stores 8
// - fast high phase from 16-bit count
// - high-speed mode uses fast counts
// - fast count writes only while disabled
// - fast high count below 6 stores 6
// - fast low count 16-bit, clamped to 8
// - general call flag set on acked call
// - general call flag held until disable or clear
// - bytes after general call go to receive buffer
// - status bit 10 reports start or restart
module i2c_scl_timing_and_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic master_run,
  input wire i2c_timing_pkg::speed_t speed,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  import i2c_timing_pkg::*;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_addr_ack = 3'b010,
    st_data = 3'b011,
    st_data_ack = 3'b100
  } rx_state_t;

  logic [15:0] std_high, std_low, fast_high, fast_low;
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic gc_flag, start_flag, sda_drive, scl_low, run;
  logic rise, fall, start_cond, stop_cond, gc_clear, start_clear;
  logic [2:0] bitcnt;
  logic [7:0] shift, next_shift;
  logic [15:0] sel_high, sel_low, hl, ll, status;
  rx_state_t state;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo);
    clamp = (v < lo) ? lo : v;
  endfunction

  // ----------------------------------------
  // count registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      std_high <= std_high_reset;
      std_low <= std_low_reset;
      fast_high <= fast_high_reset;
      fast_low <= fast_low_reset;
    end else if (wr_en && !enable) begin
      if (addr == std_high_count_off) std_high <= clamp(wdata, high_count_min);
      if (addr == std_low_count_off) std_low <= clamp(wdata, low_count_min);
      if (addr == fast_high_count_off) fast_high <= clamp(wdata, high_count_min);
      // full 16-bit write, so no split low/high byte ordering hazard here
      if (addr == fast_low_count_off) fast_low <= clamp(wdata, low_count_min);
    end
  end

  assign gc_clear = rd_en && addr == general_call_clear_off;
  assign start_clear = rd_en && addr == start_seen_clear_off;

  always_comb begin
    status = 16'h0000;
    status[general_call_bit] = gc_flag;
    status[start_seen_bit] = start_flag;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      unique case (addr)
        std_high_count_off: rdata <= std_high;
        std_low_count_off: rdata <= std_low;
        fast_high_count_off: rdata <= fast_high;
        fast_low_count_off: rdata <= fast_low;
        interrupt_status_off: rdata <= status;
        general_call_clear_off: rdata <= {15'h0, gc_flag};
        start_seen_clear_off: rdata <= {15'h0, start_flag};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // master scl timing
  // ----------------------------------------
  // no separate high-speed counts here, so high speed stays on fast timing
  assign sel_high = (speed == speed_std) ? std_high : fast_high;
  assign sel_low = (speed == speed_std) ? std_low : fast_low;
  assign run = master_run && enable;

  scl_phase_gen u_phase (
    .clk(clk),
    .rst(rst),
    .run(run),
    .high_count(sel_high),
    .low_count(sel_low),
    .scl_low(scl_low)
  );

  assign scl_out = 1'b0;
  assign scl_oe = scl_low;
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive;

  // ----------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_q} <= 3'b111;
      {sda_m, sda_s, sda_q} <= 3'b111;
    end else begin
      {scl_m, scl_s, scl_q} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
    end
  end

  assign rise = scl_s && !scl_q;
  assign fall = !scl_s && scl_q;
  assign start_cond = scl_s && scl_q && sda_q && !sda_s;
  assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
  assign next_shift = {shift[6:0], sda_s};

  // ----------------------------------------
  // slave receiver for general call
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      bitcnt <= 3'h0;
      shift <= 8'h00;
      sda_drive <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!enable || stop_cond) begin
        state <= st_idle;
        sda_drive <= 1'b0;
      end else if (start_cond) begin
        state <= st_addr;
        bitcnt <= 3'h0;
        sda_drive <= 1'b0;
      end else begin
        unique case (state)
          st_idle: ;
          st_addr, st_data: if (rise) begin
            shift <= next_shift;
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == last_bit) begin
              if (state == st_data) begin
                rx_data <= next_shift;
                rx_valid <= 1'b1;
                state <= st_data_ack;
              end else begin
                state <= (next_shift == general_call_addr) ? st_addr_ack : st_idle;
              end
            end
          end
          st_addr_ack, st_data_ack: if (fall) begin
            sda_drive <= !sda_drive;
            if (sda_drive) state <= st_data;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // set beats the clear read in the same cycle so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gc_flag <= 1'b0;
      start_flag <= 1'b0;
    end else if (!enable) begin
      gc_flag <= 1'b0;
      start_flag <= 1'b0;
    end else begin
      if (state == st_addr_ack && fall && !sda_drive && !stop_cond && !start_cond)
        gc_flag <= 1'b1;
      else if (gc_clear)
        gc_flag <= 1'b0;
      if (start_cond)
        start_flag <= 1'b1;
      else if (start_clear)
        start_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hl <= 16'h0000;
      ll <= 16'h0000;
    end else begin
      hl <= (run && !scl_low) ? hl + 16'h0001 : 16'h0000;
      ll <= (run && scl_low) ? ll + 16'h0001 : 16'h0000;
    end
  end

  std_low_clamp_a: assert property (@(posedge clk) disable iff (rst)
    wr_en && !enable && addr == std_low_count_off && wdata < low_count_min |=> std_low == low_count_min)
    else $error("standard low count not clamped");
  fast_high_clamp_a: assert property (@(posedge clk) disable iff (rst)
    wr_en && !enable && addr == fast_high_count_off |=> fast_high == clamp($past(wdata), high_count_min))
    else $error("fast high count not clamped");
  fast_low_clamp_a: assert property (@(posedge clk) disable iff (rst)
    wr_en && !enable && addr == fast_low_count_off |=> fast_low == clamp($past(wdata), low_count_min))
    else $error("fast low count not clamped");
  locked_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_en && enable |=> $stable(fast_high) && $stable(fast_low))
    else $error("fast count changed while enabled");
  high_phase_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(scl_oe) |-> hl == sel_high)
    else $error("scl high phase wrong length");
  low_phase_len_a: assert property (@(posedge clk) disable iff (rst)
    $fell(scl_oe) && $past(run) && run |-> ll == sel_low)
    else $error("scl low phase wrong length");
  gc_set_cause_a: assert property (@(posedge clk) disable iff (rst)
    $rose(gc_flag) |-> $past(state == st_addr_ack && fall) ##0 sda_drive)
    else $error("general call flag set without ack");
  gc_hold_a: assert property (@(posedge clk) disable iff (rst)
    gc_flag && enable && !gc_clear |=> gc_flag || !enable)
    else $error("general call flag dropped");
  rx_push_a: assert property (@(posedge clk) disable iff (rst)
    rx_valid |-> $past(state == st_data) && state == st_data_ack && rx_data == shift)
    else $error("receive byte pushed outside data phase");
  start_flag_a: assert property (@(posedge clk) disable iff (rst)
    start_cond && enable |=> start_flag)
    else $error("start not reported");
  status_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == interrupt_status_off |=> rdata[15:12] == 4'h0)
    else $error("unused status bits not zero");
endmodule

// >>> design/scl_phase_gen.sv
// Purpose: times scl high and low phases from two cycle counts
// Assumes: counts do not change while run is high
// Notes: scl_low is registered; high phase comes first after run rises
module scl_phase_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [15:0] high_count,
  input wire logic [15:0] low_count,
  output logic scl_low
);
  logic [15:0] cnt;

  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
      scl_low <= 1'b0;
    end else if (!run) begin
      cnt <= 16'h0000;
      scl_low <= 1'b0;
    end else if (!scl_low && cnt == high_count - 16'h0001) begin
      cnt <= 16'h0000;
      scl_low <= 1'b1;
    end else if (scl_low && cnt == low_count - 16'h0001) begin
      cnt <= 16'h0000;
      scl_low <= 1'b0;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// >>> shared/i2c_timing_pkg.sv
// Purpose: constants for the scl timing and bus status block
// Assumes: 16-bit register data, byte addresses as printed
// Notes: clear register offsets sit 0x38 and 0x3c above the status register
package i2c_timing_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [31:0] std_high_count_off = 32'h50001314;
  localparam logic [31:0] std_low_count_off = 32'h50001318;
  localparam logic [31:0] fast_high_count_off = 32'h5000131c;
  localparam logic [31:0] fast_low_count_off = 32'h50001320;
  localparam logic [31:0] interrupt_status_off = 32'h5000132c;
  localparam logic [31:0] general_call_clear_off = 32'h50001368;
  localparam logic [31:0] start_seen_clear_off = 32'h50001364;
  // ----------------------------------------
  // reset values and lower limits
  // ----------------------------------------
  localparam logic [15:0] std_high_reset = 16'h0048;
  localparam logic [15:0] std_low_reset = 16'h004f;
  localparam logic [15:0] fast_high_reset = 16'h0008;
  localparam logic [15:0] fast_low_reset = 16'h0017;
  localparam logic [15:0] high_count_min = 16'h0006;
  localparam logic [15:0] low_count_min = 16'h0008;
  // ----------------------------------------
  // status fields and bus constants
  // ----------------------------------------
  localparam int general_call_bit = 11;
  localparam int start_seen_bit = 10;
  localparam logic [7:0] general_call_addr = 8'h00;
  localparam logic [2:0] last_bit = 3'h7;
  typedef enum logic [1:0] {
    speed_std = 2'b01,
    speed_fast = 2'b10,
    speed_high = 2'b11
  } speed_t;
endpackage

// >>> tb/i2c_bus_master_model.sv
// Purpose: far-side bus master that sends start, bytes and stop on the two-wire bus
// Assumes: both lines have pull-ups; a high output pulls the line down
// Notes: bit period 125 ns; scl stands high between frames
module i2c_bus_master_model (
  output logic scl_low,
  output logic sda_low,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // also serves as repeated start: releases sda while scl is low first
  task automatic start_cond();
    sda_low = 1'b0;
    #31;
    scl_low = 1'b0;
    #31;
    sda_low = 1'b1;
    #31;
    scl_low = 1'b1;
    #32;
  endtask
  // msb first, then a released ninth bit sampled while scl is high
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #31;
      scl_low = 1'b0;
      #62.5;
      scl_low = 1'b1;
      #31.5;
    end
    sda_low = 1'b0;
    #31;
    scl_low = 1'b0;
    #31;
    ack = ~sda_line;
    #31.5;
    scl_low = 1'b1;
    #31.5;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    #31;
    scl_low = 1'b0;
    #31;
    sda_low = 1'b0;
    #31;
  endtask
endmodule

// >>> tb/test_i2c_scl_timing_and_status.sv
// Purpose: self-checking bench for scl counts, master scl timing and bus status
// Assumes: bus master model on the far side, pull-ups on both lines
// Notes: register and control inputs change at the falling clock edge; bus lines follow the model's own delays
module test_i2c_scl_timing_and_status;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_timing_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk = 1'b0, rst = 1'b1, enable = 1'b0, master_run = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  speed_t speed = speed_fast;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0, rdata, d;
  logic scl_out, scl_oe, sda_out, sda_oe, rx_valid, m_scl_low, m_sda_low, ack;
  logic [7:0] rx_data, rx_last = 8'h0;
  // wired-and of both sides, pull-up wins when nobody pulls low
  wire scl_in = !m_scl_low && !(scl_oe && !scl_out);
  wire sda_in = !m_sda_low && !(sda_oe && !sda_out);
  int error_cnt = 0, checks_done = 0, cycles = 0;
  i2c_scl_timing_and_status DUT (.clk(clk), .rst(rst), .enable(enable),
    .master_run(master_run), .speed(speed), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .rx_data(rx_data),
    .rx_valid(rx_valid));
  i2c_bus_master_model model (.scl_low(m_scl_low), .sda_low(m_sda_low), .sda_line(sda_in));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rx_last <= rx_data;
    cycles++;
    // ceiling well above the roughly 1500 cycles the tests need
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    v = rdata;
  endtask
  task automatic wrchk(input string n, input logic [31:0] a, input logic [15:0] v, e);
    wr(a, v);
    rd(a, d);
    chk(n, e, d);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_clamp();
    wrchk("fast high 3", fast_high_count_off, 16'h0003, 16'h0006);
    wrchk("fast high 5", fast_high_count_off, 16'h0005, 16'h0006);
    wrchk("fast high 7", fast_high_count_off, 16'h0007, 16'h0007);
    wrchk("fast low 7", fast_low_count_off, 16'h0007, 16'h0008);
    wrchk("fast low max", fast_low_count_off, 16'hffff, 16'hffff);
    wrchk("std low 2", std_low_count_off, 16'h0002, 16'h0008);
    wrchk("std low 9", std_low_count_off, 16'h0009, 16'h0009);
    wr(fast_high_count_off, 16'h0006);
    wr(fast_low_count_off, 16'h0008);
    @(negedge clk);
    enable = 1'b1;
    wrchk("locked high", fast_high_count_off, 16'h0040, 16'h0006);
    wrchk("locked low", fast_low_count_off, 16'h0040, 16'h0008);
    $display("clamp and lock test finished");
  endtask
  task automatic t_scl(input speed_t spd, input logic [15:0] eh, el);
    int n, m;
    @(negedge clk);
    speed = spd;
    master_run = 1'b1;
    n = 0;
    m = 0;
    // every edge with run high counts, the one that pulls scl low included
    while (scl_oe !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("scl drive level", 16'h0000, {15'h0, scl_out});
    while (scl_oe === 1'b1 && m < 100) begin
      @(posedge clk);
      #1;
      m++;
    end
    chk("scl high cycles", eh, 16'(n));
    chk("scl low cycles", el, 16'(m));
    @(negedge clk);
    master_run = 1'b0;
    repeat (3) @(posedge clk);
    $display("scl timing test finished");
  endtask
  task automatic t_gc();
    model.start_cond();
    rd(interrupt_status_off, d);
    chk("start flag", 16'h0400, d);
    model.send_byte(general_call_addr, ack);
    chk("call ack", 16'h0001, {15'h0, ack});
    chk("sda drive level", 16'h0000, {15'h0, sda_out});
    model.send_byte(8'ha5, ack);
    chk("rx byte", 16'h00a5, {8'h0, rx_last});
    chk("data ack", 16'h0001, {15'h0, ack});
    model.start_cond();
    model.send_byte(8'h5a, ack);
    chk("other addr ack", 16'h0000, {15'h0, ack});
    rd(interrupt_status_off, d);
    chk("flags held", 16'h0c00, d);
    rd(general_call_clear_off, d);
    chk("clear read", 16'h0001, d);
    rd(interrupt_status_off, d);
    chk("after clear", 16'h0400, d);
    rd(start_seen_clear_off, d);
    chk("start clear read", 16'h0001, d);
    rd(interrupt_status_off, d);
    chk("start cleared", 16'h0000, d);
    model.start_cond();
    model.send_byte(general_call_addr, ack);
    model.stop_cond();
    rd(interrupt_status_off, d);
    chk("flag set again", 16'h0c00, d);
    @(negedge clk);
    enable = 1'b0;
    rd(interrupt_status_off, d);
    chk("disable clears", 16'h0000, d);
    $display("general call test finished");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(fast_high_count_off, d);
    chk("high reset", fast_high_reset, d);
    rd(fast_low_count_off, d);
    chk("low reset", fast_low_reset, d);
    rd(interrupt_status_off, d);
    chk("status reset", 16'h0000, d);
    rd(32'h50001330, d);
    chk("unmapped", 16'h0000, d);
    $display("reset test finished");
    t_clamp();
    t_scl(speed_fast, 16'h0006, 16'h0008);
    t_scl(speed_high, 16'h0006, 16'h0008);
    t_scl(speed_std, std_high_reset, 16'h0009);
    t_gc();
    complete_run();
  end
endmodule
